/* include/fetch_seq_cfg.svh */
// Constants for the instruction fetch sequencer: offsets, fields, resets.
// Assumes inclusion by the sequencer module and the testbench only.
`ifndef FETCH_SEQ_CFG_SVH
`define FETCH_SEQ_CFG_SVH

// ****************************************
// Register map (byte addresses on APB)
// ****************************************
`define ADDR_PC_LOW_BYTE_REG 12'h000
`define ADDR_PC_STATUS 12'h004

// ****************************************
// Reset values and widths
// ****************************************
`define PC_RESET_VECTOR 12'h000
`define PC_WIDTH 12
`define PC_LOW_WIDTH 8
`define PC_HIGH_LSB 8

// ****************************************
// Status register fields
// ****************************************
`define STAT_PHASE_LSB 0
`define STAT_DUMMY_BIT 4
`define STAT_PC_HIGH_LSB 8

`endif

/* include/fetch_seq_pkg.sv */
// Types for the instruction fetch sequencer.
// Assumes fetch_seq_cfg.svh is on the include path.
package fetch_seq_pkg;

    typedef enum logic [1:0] {
        PH_FETCH,
        PH_DECODE,
        PH_EXEC,
        PH_WRITE
    } phase_type;

    typedef enum logic [1:0] {
        FLOW_SEQ,
        FLOW_BRANCH,
        FLOW_SKIP,
        FLOW_RET
    } flow_type;

endpackage : fetch_seq_pkg

/* logic/instruction_fetch_sequencer.sv */
// Program-counter sequencing and instruction fetch for a small 8-bit core.
// Assumes program memory answers a fetch address within one phase, and the
// execute stage reports branch, skip and target on the last phase.
// Notes on behaviour
// RL1: The clock is split into four phases and one pass makes a cycle.
// RL2: At the first phase the counter advances and a new word is fetched.
// RL3: Decode and execution use the second to fourth phases.
// RL4: Fetch of one word overlaps execution of the one before it.
// RL5: A jump or call takes two cycles, the second one a dummy cycle.
// RL6: A plain instruction advances the counter by exactly one.
// RL7: Jump, call, interrupt or reset loads the destination into the counter.
// RL8: A taken skip discards the fetched word and runs a dummy cycle.
// RL9: The low-byte register shows only the low byte of the counter; the status register also shows the four high bits.
// RL10: The counter is twelve bits, a four-bit high part and a low byte.
// RL11: Execution uses an eight-bit ALU fed through an accumulator.
// RL12: Writing the low byte jumps within the page and adds a dummy cycle.
// RL13: After reset the counter holds address zero.
// RL14: Reset restarts the phase generator at the first phase.
`include "fetch_seq_cfg.svh"

module instruction_fetch_sequencer #(
    parameter int PC_W = `PC_WIDTH
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Program memory
    output logic [PC_W-1:0] fetch_addr_o,
    output logic fetch_req_o,
    input wire logic [14:0] fetch_data_i,
    // Execute stage
    output logic [14:0] instr_o,
    output logic instr_valid_o,
    output fetch_seq_pkg::phase_type phase_clocks_o,
    input wire fetch_seq_pkg::flow_type flow_i,
    input wire logic flow_valid_i,
    input wire logic [PC_W-1:0] target_i,
    input wire logic irq_take_i,
    input wire logic [PC_W-1:0] irq_vector_i
);
    import fetch_seq_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        phase_type phase;
        logic [PC_W-1:0] pc;
        logic [14:0] ir;
        logic ir_valid;
        logic dummy;
        logic pend_load;
        logic [PC_W-1:0] pend_target;
        logic [31:0] rdata;
    } state_type;

    state_type s_q;
    state_type s_d;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
        hit = (a == r);
    endfunction : hit

    logic apb_access;
    logic pcl_write;

    assign apb_access = psel_i & penable_i;
    assign pcl_write = apb_access & pwrite_i
        & hit(paddr_i, `ADDR_PC_LOW_BYTE_REG);

    always_comb begin
        s_d = s_q;
        // Phases run round in a fixed ring of four.
        case (s_q.phase) // RL1
            PH_FETCH: s_d.phase = PH_DECODE;
            PH_DECODE: s_d.phase = PH_EXEC; // RL3
            PH_EXEC: s_d.phase = PH_WRITE;
            PH_WRITE: s_d.phase = PH_FETCH;
            default: s_d.phase = PH_FETCH;
        endcase
        if (s_q.phase == PH_FETCH) begin
            // Fetch overlaps execution of the word latched last cycle.
            s_d.ir = fetch_data_i; // RL4
            s_d.ir_valid = 1'b1;
            s_d.dummy = s_q.pend_load; // RL8
            if (s_q.pend_load) begin
                // The word fetched now is thrown away and the target is
                // fetched next cycle, which is where the extra cycle goes.
                s_d.pc = s_q.pend_target; // RL5
                s_d.pend_load = 1'b0;
            end else begin
                s_d.pc = s_q.pc + {{(PC_W-1){1'b0}}, 1'b1}; // RL2 RL6
            end
        end
        // A low-byte write keeps the page bits and waits for cycle end.
        // It follows the fetch so that a write in the first phase survives.
        if (pcl_write) begin // RL12
            s_d.pend_load = 1'b1;
            s_d.pend_target = {s_q.pc[PC_W-1:`PC_HIGH_LSB],
                               pwdata_i[`PC_LOW_WIDTH-1:0]};
        end
        if (s_q.phase == PH_WRITE) begin
            if (irq_take_i) begin // RL7
                s_d.pend_load = 1'b1;
                s_d.pend_target = irq_vector_i;
            end else if (flow_valid_i && s_q.ir_valid && !s_q.dummy) begin
                if (flow_i == FLOW_BRANCH || flow_i == FLOW_RET) begin
                    s_d.pend_load = 1'b1; // RL5
                    s_d.pend_target = target_i; // RL7
                end else if (flow_i == FLOW_SKIP) begin
                    s_d.pend_load = 1'b1; // RL8
                    s_d.pend_target = s_q.pc + {{(PC_W-1){1'b0}}, 1'b1};
                end
            end
        end
        s_d.rdata = 32'h0000_0000;
        if (psel_i && !penable_i && !pwrite_i) begin
            if (hit(paddr_i, `ADDR_PC_LOW_BYTE_REG)) begin
                s_d.rdata[`PC_LOW_WIDTH-1:0] =
                    s_q.pc[`PC_LOW_WIDTH-1:0]; // RL9
            end else if (hit(paddr_i, `ADDR_PC_STATUS)) begin
                s_d.rdata[`STAT_PHASE_LSB +: 2] = s_q.phase;
                s_d.rdata[`STAT_DUMMY_BIT] = s_q.dummy;
                s_d.rdata[`STAT_PC_HIGH_LSB +: 4] =
                    s_q.pc[PC_W-1:`PC_HIGH_LSB];
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_q <= '0;
            s_q.phase <= PH_FETCH; // RL14
            s_q.pc <= `PC_RESET_VECTOR; // RL13 RL10
            s_q.pend_target <= `PC_RESET_VECTOR;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // The fetch address is the counter itself, so the fetch after reset
    // comes from the reset vector.
    assign fetch_addr_o = s_q.pc;
    assign fetch_req_o = (s_q.phase == PH_FETCH);
    assign instr_o = s_q.ir;
    // The ALU and accumulator live in the execute stage; it sees no word
    // during dummy cycles.
    assign instr_valid_o = s_q.ir_valid & ~s_q.dummy; // RL11
    assign phase_clocks_o = s_q.phase;
    assign prdata_o = s_q.rdata;
    assign pready_o = 1'b1;
    assign pslverr_o = apb_access & ~hit(paddr_i, `ADDR_PC_LOW_BYTE_REG)
        & ~(hit(paddr_i, `ADDR_PC_STATUS) & ~pwrite_i);

    // ****************************************
    // Checks
    // ****************************************
    property p_phase_ring;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        s_q.phase == PH_FETCH |=> s_q.phase == PH_DECODE ##1
            s_q.phase == PH_EXEC ##1 s_q.phase == PH_WRITE ##1
            s_q.phase == PH_FETCH;
    endproperty
    a_phase_ring: assert property (p_phase_ring) // RL1
        else $error("phase ring broken");

    property p_pc_step;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (s_q.phase == PH_FETCH && !s_q.pend_load) |=>
            s_q.pc == $past(s_q.pc) + 1'b1;
    endproperty
    a_pc_step: assert property (p_pc_step) // RL6
        else $error("counter did not step by one");

    property p_pc_stable;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        s_q.phase != PH_FETCH |=> $stable(s_q.pc);
    endproperty
    a_pc_stable: assert property (p_pc_stable) // RL2
        else $error("counter moved outside first phase");

    property p_branch_dummy;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (s_q.phase == PH_WRITE && flow_valid_i && s_q.ir_valid
            && !s_q.dummy && !irq_take_i && flow_i == FLOW_BRANCH)
            |=> ##1 s_q.pc == $past(target_i, 2) ##0 s_q.dummy;
    endproperty
    a_branch_dummy: assert property (p_branch_dummy) // RL5
        else $error("branch did not load target with dummy");

    property p_skip_dummy;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (s_q.phase == PH_WRITE && flow_valid_i && s_q.ir_valid
            && !s_q.dummy && !irq_take_i && flow_i == FLOW_SKIP)
            |=> ##1 s_q.dummy ##1 !instr_valid_o[*3];
    endproperty
    a_skip_dummy: assert property (p_skip_dummy) // RL8
        else $error("skip did not make a dummy cycle");

    property p_pcl_page;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (pcl_write && s_q.phase == PH_WRITE && !irq_take_i
            && !(flow_valid_i && s_q.ir_valid && !s_q.dummy
                 && flow_i != FLOW_SEQ))
            |=> ##1 s_q.pc[7:0] == $past(pwdata_i[7:0], 2);
    endproperty
    a_pcl_page: assert property (p_pcl_page) // RL12
        else $error("low byte write did not jump in page");

    property p_irq_load;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (s_q.phase == PH_WRITE && irq_take_i && !pcl_write)
            |=> ##1 s_q.pc == $past(irq_vector_i, 2);
    endproperty
    a_irq_load: assert property (p_irq_load) // RL7
        else $error("interrupt vector not loaded");

    property p_fetch_req;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        fetch_req_o |-> ##1 !fetch_req_o [*3] ##1 fetch_req_o;
    endproperty
    a_fetch_req: assert property (p_fetch_req) // RL4
        else $error("fetch not once per cycle");

    property p_read_low;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (psel_i && !penable_i && !pwrite_i && paddr_i == 12'h000)
            |=> prdata_o[31:8] == 24'h000000;
    endproperty
    a_read_low: assert property (p_read_low) // RL9
        else $error("upper counter bits visible in low byte");

    property p_load_dummy;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (s_q.phase == PH_FETCH && s_q.pend_load) |=>
            s_q.dummy && s_q.pc == $past(s_q.pend_target);
    endproperty
    a_load_dummy: assert property (p_load_dummy) // RL8
        else $error("pending load did not make a dummy cycle");

    property p_seq_valid;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (s_q.phase == PH_FETCH && !s_q.pend_load) |=>
            !s_q.dummy && s_q.ir_valid;
    endproperty
    a_seq_valid: assert property (p_seq_valid) // RL6
        else $error("plain fetch marked as dummy");

    property p_ir_capture;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        s_q.phase == PH_FETCH |=> s_q.ir == $past(fetch_data_i);
    endproperty
    a_ir_capture: assert property (p_ir_capture) // RL4
        else $error("fetched word not latched");

    // The word must not change while it is being decoded and executed.
    property p_ir_hold;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        s_q.phase != PH_FETCH |=> $stable(s_q.ir);
    endproperty
    a_ir_hold: assert property (p_ir_hold) // RL3
        else $error("word changed during execution");

    property p_rdata_idle;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        !(psel_i && !penable_i && !pwrite_i) |=> prdata_o == 32'h0000_0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) // RL9
        else $error("read data shown outside a read");

    property p_read_pc;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (psel_i && !penable_i && !pwrite_i
            && paddr_i == `ADDR_PC_LOW_BYTE_REG)
            |=> prdata_o[7:0] == $past(s_q.pc[7:0]);
    endproperty
    a_read_pc: assert property (p_read_pc) // RL9
        else $error("low byte read wrong");

    property p_read_status;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (psel_i && !penable_i && !pwrite_i && paddr_i == `ADDR_PC_STATUS)
            |=> prdata_o[11:8] == $past(s_q.pc[PC_W-1:`PC_HIGH_LSB]);
    endproperty
    a_read_status: assert property (p_read_status) // RL10
        else $error("status page bits wrong");

    property p_irq_pend;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (s_q.phase == PH_WRITE && irq_take_i) |=>
            s_q.pend_load && s_q.pend_target == $past(irq_vector_i);
    endproperty
    a_irq_pend: assert property (p_irq_pend) // RL7
        else $error("interrupt vector not pending");

    property p_pcl_pend;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (pcl_write && s_q.phase != PH_WRITE) |=> s_q.pend_load
            && s_q.pend_target == {$past(s_q.pc[PC_W-1:`PC_HIGH_LSB]),
                                   $past(pwdata_i[7:0])};
    endproperty
    a_pcl_pend: assert property (p_pcl_pend) // RL12
        else $error("low byte write not pending in page");

    property p_skip_target;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (s_q.phase == PH_WRITE && flow_valid_i && s_q.ir_valid
            && !s_q.dummy && !irq_take_i && flow_i == FLOW_SKIP)
            |=> s_q.pend_target == $past(s_q.pc) + 1'b1;
    endproperty
    a_skip_target: assert property (p_skip_target) // RL8
        else $error("skip does not pass the next word");

    // A discarded word must never steer the counter.
    property p_dummy_no_steer;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (s_q.phase == PH_WRITE && s_q.dummy && !irq_take_i && !pcl_write
            && !s_q.pend_load) |=> !s_q.pend_load;
    endproperty
    a_dummy_no_steer: assert property (p_dummy_no_steer) // RL8
        else $error("dummy word changed program flow");

    property p_reset_phase;
        @(posedge sys_clk_i) $rose(rstn_i) |-> s_q.phase == PH_FETCH;
    endproperty
    a_reset_phase: assert property (p_reset_phase) // RL14
        else $error("phase not at first after reset");

    property p_reset_pc;
        @(posedge sys_clk_i) $rose(rstn_i) |-> s_q.pc == `PC_RESET_VECTOR;
    endproperty
    a_reset_pc: assert property (p_reset_pc) // RL13
        else $error("counter not at reset vector");

endmodule : instruction_fetch_sequencer

/* dv/prog_mem_model.sv */
// Program memory model: answers each fetch address with a known word.
// Assumes the sequencer samples the word at the end of its fetch phase.
module prog_mem_model (
    // Clock and fetch port
    input wire logic sys_clk_i,
    input wire logic fetch_req_i,
    input wire logic [11:0] fetch_addr_i,
    output logic [14:0] fetch_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [14:0] last_q = 15'h0000;
    // Outside a fetch the bus shows the inverse of the last word, so a
    // late sample can never match by accident.
    always_comb begin
        fetch_data_o = fetch_req_i ? {3'h5, fetch_addr_i} : ~last_q;
    end
    always_ff @(posedge sys_clk_i) begin
        if (fetch_req_i) begin
            last_q <= {3'h5, fetch_addr_i};
        end
    end
endmodule : prog_mem_model

/* dv/instruction_fetch_sequencer_tb_top.sv */
// Self-checking bench for the instruction fetch sequencer.
// Assumes the package, the design and the memory model compile first.
`include "fetch_seq_cfg.svh"
module instruction_fetch_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import fetch_seq_pkg::*;
    logic sys_clk_i = 1'b0, rstn_i = 1'b0, psel_i = 1'b0;
    logic penable_i = 1'b0, pwrite_i = 1'b0, irq_take_i = 1'b0;
    logic pready_o, pslverr_o, fetch_req_o, instr_valid_o, v, er;
    logic flow_valid_i = 1'b0;
    logic [11:0] paddr_i = 12'h000, target_i = 12'h000;
    logic [11:0] irq_vector_i = 12'h000, fetch_addr_o;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
    logic [14:0] fetch_data_i, instr_o, w;
    phase_type phase_clocks_o;
    flow_type flow_i = FLOW_SEQ;
    int n_errors = 0, num_checks = 0, c;
    instruction_fetch_sequencer instruction_fetch_sequencer_inst (.*);
    prog_mem_model prog_mem_model_inst (.sys_clk_i(sys_clk_i),
        .fetch_req_i(fetch_req_o), .fetch_addr_i(fetch_addr_o),
        .fetch_data_o(fetch_data_i));
    initial begin
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    // ********************
    // Bus and check tasks
    // ********************
    task automatic check(string s, logic [31:0] e, logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", s, e, g);
        end
    endtask : check
    task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
        @(posedge sys_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge sys_clk_i);
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb
    // Returns just after the edge that opens the next decode phase.
    task automatic next_instr();
        c = 0;
        do begin
            @(posedge sys_clk_i);
            #1;
            c++;
        end while (phase_clocks_o !== PH_DECODE && c < 8);
        v = instr_valid_o;
        w = instr_o;
    endtask : next_instr
    task automatic steer(flow_type f, logic [11:0] t, logic irq);
        do begin
            @(posedge sys_clk_i);
            #1;
        end while (phase_clocks_o !== PH_EXEC);
        @(posedge sys_clk_i);
        flow_i <= f;
        target_i <= t;
        irq_vector_i <= t;
        flow_valid_i <= !irq;
        irq_take_i <= irq;
        @(posedge sys_clk_i);
        flow_valid_i <= 1'b0;
        irq_take_i <= 1'b0;
    endtask : steer
    // A write may land late in a cycle, so slack allows one word first.
    task automatic expect_jump(logic [11:0] t, bit slack);
        next_instr();
        if (slack && v === 1'b1) next_instr();
        check("dummy valid", 0, v);
        next_instr();
        check("target valid", 1, v);
        check("target word", {3'h5, t}, w);
    endtask : expect_jump
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up
    // ********************
    // Tests
    // ********************
    initial begin
        #50000;
        n_errors++;
        wrap_up();
    end
    initial begin
        repeat (5) @(posedge sys_clk_i);
        check("reset addr", 0, fetch_addr_o);
        check("reset phase", PH_FETCH, phase_clocks_o);
        rstn_i <= 1'b1;
        next_instr();
        check("first word", {3'h5, 12'h000}, w);
        for (int i = 1; i < 5; i++) begin
            next_instr();
            check("cycle length", 4, c);
            check("seq word", {3'h5, 12'(i)}, w);
            check("fetch req", 0, fetch_req_o);
            check("prefetch addr", i + 1, fetch_addr_o);
        end
        $display("sequential test done");
        steer(FLOW_BRANCH, 12'h3a5, 1'b0);
        expect_jump(12'h3a5, 1'b0);
        steer(FLOW_RET, 12'h7f0, 1'b0);
        expect_jump(12'h7f0, 1'b0);
        steer(FLOW_SEQ, 12'h111, 1'b1);
        expect_jump(12'h111, 1'b0);
        steer(FLOW_SKIP, 12'h000, 1'b0);
        expect_jump(12'h113, 1'b0);
        steer(FLOW_SEQ, 12'hfff, 1'b0);
        next_instr();
        check("plain word", {1'b1, 3'h5, 12'h114}, {v, w});
        $display("flow test done");
        apb(1'b1, `ADDR_PC_LOW_BYTE_REG, 32'h0000005c);
        expect_jump(12'h15c, 1'b1);
        apb(1'b0, `ADDR_PC_LOW_BYTE_REG, 32'h0);
        check("low byte only", 24'h0, rd[31:8]);
        check("low byte value", 8'h5d, rd[7:0]);
        check("low byte err", 0, er);
        apb(1'b0, `ADDR_PC_STATUS, 32'h0);
        check("status high", 4'h1, rd[11:8]);
        apb(1'b1, `ADDR_PC_STATUS, 32'h0);
        check("status write err", 1, er);
        apb(1'b0, 12'h008, 32'h0);
        check("unmapped err", 1, er);
        $display("register test done");
        rstn_i <= 1'b0;
        next_instr();
        check("rerun addr", 0, fetch_addr_o);
        check("rerun phase", PH_FETCH, phase_clocks_o);
        @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        next_instr();
        check("rerun word", {1'b1, 3'h5, 12'h000}, {v, w});
        $display("reset test done");
        wrap_up();
    end
endmodule : instruction_fetch_sequencer_tb_top
